// ===== hdl/dwc_checker.sv
/*
 * Write-data checksum checker of the memory device: samples the strobe
 * and data pins, captures ten-beat write frames, recomputes the eight-bit
 * checksum per byte tree, raises alert and steers the array write.
 * Assumes write commands come from same-clock decode logic and the strobe
 * idles low between frames, toggling once per beat (center aligned).
 */
// Our own choices: the address-and-strobe port and the register offsets.
// Contract
// [RQ1] Masked mode: check before commit, cancel on error
// [RQ2] Controller avoids register-page and per-device writes
// [RQ3] Polynomial x^8+x^2+x+1
// [RQ4] Eight-bit result from 72 data bits
// [RQ5] Bit 71 enters the checksum first
// [RQ6] Checksum starts from zero every word
// [RQ7] Detect all single, double, odd errors
// [RQ8] Detect column errors outside inversion lane
// [RQ9] Full bursts use fixed order zero
// [RQ10] Narrow device lane and checksum mapping
// [RQ11] Byte device lane mapping, mask lane
// [RQ12] Wide device is two byte devices
// [RQ13] Lower tree bits 71:0, upper 143:72
// [RQ14] Chopped bursts: A2 selects critical half
// [RQ15] Mismatch drives alert output
// [RQ16] Check raw data, restore inversion afterwards
// [RQ17] Unmasked mode may commit before checking
// [RQ18] Controller drives ones on unused mask lane
// [RQ19] Compare after all ten beats, once
// [RQ20] Either wide tree fails the device
module dwc_checker #(
   parameter int unsigned ALERT_CYC = dwc_pkg::ALERT_CYC
) (
   // Clock and reset
   input  wire  logic        clk,
   input  wire  logic        srst,
   // Register port
   input  wire  logic [3:0]  reg_addr,
   input  wire  logic [31:0] reg_wdata,
   input  wire  logic        reg_wr,
   input  wire  logic        reg_rd,
   output logic        [31:0] reg_rdata,
   // Command decode
   input  wire  logic        wr_cmd,
   input  wire  logic [2:0]  wr_col,
   input  wire  logic        mpr_wr_cmd,
   input  wire  logic        pda_cmd,
   // Data pins
   input  wire  logic        dqs_i,
   input  wire  logic [15:0] dq_i,
   input  wire  logic [1:0]  dm_n_i,
   // Alert pin, open drain
   output logic              alert_o,
   output logic              alert_oe_n,
   // Array write port
   output logic [127:0]      arr_data,
   output logic [15:0]       arr_mask,
   output logic              arr_commit,
   output logic              arr_cancel
);
   // ==========================================================
   // State
   // ==========================================================
   typedef enum logic [1:0] {IDLE, RECV, CHECK} dwc_st_t;
   typedef logic [dwc_pkg::BEATS-1:0][dwc_pkg::LANES-1:0] dwc_beats_t;

   typedef struct packed {
      dwc_st_t     st;
      logic [2:0]  dqs_sy;
      logic [dwc_pkg::LANES-1:0] ln_s1;
      logic [dwc_pkg::LANES-1:0] ln_s2;
      dwc_beats_t  bt;
      logic [3:0]  cnt;
      logic        a2;
      logic        crc_en;
      logic        dm_en;
      logic        dbi_en;
      logic [1:0]  wid;
      logic        bc4;
      logic        err;
      logic        viol;
      logic [7:0]  err_cnt;
      logic [15:0] calc;
      logic [15:0] recv;
      logic        bad;
      logic        early;
      logic [31:0] rdata;
      logic [7:0]  alert_cnt;
      logic        alert_o;
      logic        alert_oe_n;
      logic [127:0] data;
      logic [15:0] mask;
      logic        commit;
      logic        cancel;
   } dwc_state_t;

   dwc_state_t s_r;
   dwc_state_t s_nxt;

   // ==========================================================
   // Checksum
   // ==========================================================
   // Serial form, MSB first from a zero register; synthesis flattens it.
   function automatic logic [7:0] crc8(input logic [dwc_pkg::WORD-1:0] d);
      logic [7:0] c;
      c = '0;                                                    // RQ6
      for (int i = dwc_pkg::WORD - 1; i >= 0; i--) begin         // RQ5
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? dwc_pkg::POLY : 8'h00); // RQ3
      end
      return c;                                                  // RQ4
   endfunction : crc8

   // Builds the 72-bit code word of one tree from the captured beats
   function automatic logic [dwc_pkg::WORD-1:0] word(input dwc_beats_t bt,
         input int unsigned base, input logic [1:0] wid, input logic bc4,
         input logic a2);
      logic [dwc_pkg::WORD-1:0] w;
      w = '1;
      for (int k = 0; k < dwc_pkg::TREE_LANES; k++) begin
         for (int b = 0; b < dwc_pkg::DATA_BEATS; b++) begin
            if (wid == dwc_pkg::W_X4 && k >= dwc_pkg::X4_LANES) begin
               w[k*dwc_pkg::BYTE_W+b] = 1'b1;                    // RQ10
            end else if (bc4) begin
               // Chopped: first four beats land in the half that A2 names
               if ((b >= dwc_pkg::HALF_BEATS) == a2) begin       // RQ14
                  w[k*dwc_pkg::BYTE_W+b] = bt[b%dwc_pkg::HALF_BEATS][base+k];
               end
            end else begin
               w[k*dwc_pkg::BYTE_W+b] = bt[b][base+k];           // RQ11
            end
         end
      end
      return w;
   endfunction : word

   logic [dwc_pkg::WORD-1:0] w_lo;
   logic [dwc_pkg::WORD-1:0] w_hi;
   logic [15:0] rx_crc;
   always_comb begin
      w_lo = word(s_r.bt, 0, s_r.wid, s_r.bc4, s_r.a2);                     // RQ13
      w_hi = word(s_r.bt, dwc_pkg::TREE_LANES, s_r.wid, s_r.bc4, s_r.a2);   // RQ12
      rx_crc = '1;
      for (int k = 0; k < dwc_pkg::BYTE_W; k++) begin
         if (s_r.wid == dwc_pkg::W_X4) begin
            rx_crc[k] = (k < dwc_pkg::X4_LANES) ? s_r.bt[dwc_pkg::CRC_BEAT0][k]
                      : s_r.bt[dwc_pkg::CRC_BEAT1][k-dwc_pkg::X4_LANES]; // RQ10
         end else begin
            rx_crc[k] = s_r.bt[dwc_pkg::CRC_BEAT0][k];
            rx_crc[k+dwc_pkg::BYTE_W] = s_r.bt[dwc_pkg::CRC_BEAT0][k+dwc_pkg::TREE_LANES];
         end
      end
   end

   // ==========================================================
   // Next state
   // ==========================================================
   logic        edge_det;
   logic        gated;
   logic [15:0] calc;
   logic        bad;
   logic [3:0]  last;
   always_comb begin
      s_nxt = s_r;
      s_nxt.dqs_sy = {s_r.dqs_sy[1:0], dqs_i};
      s_nxt.ln_s1  = {dm_n_i[1], dq_i[15:8], dm_n_i[0], dq_i[7:0]};
      s_nxt.ln_s2  = s_r.ln_s1;
      s_nxt.commit = 1'b0;
      s_nxt.cancel = 1'b0;
      edge_det = s_r.dqs_sy[1] ^ s_r.dqs_sy[2];
      gated = s_r.crc_en && s_r.dm_en;
      calc = {crc8(w_hi), crc8(w_lo)};
      // Narrow and byte devices use only the lower tree
      bad = (calc[7:0] != rx_crc[7:0]) ||                       // RQ7 RQ8
            (s_r.wid == dwc_pkg::W_X16 && calc[15:8] != rx_crc[15:8]); // RQ20
      last = s_r.crc_en ? 4'(dwc_pkg::BEATS) : 4'(dwc_pkg::DATA_BEATS);

      // Array image: inversion undone, mask per byte group and beat
      for (int g = 0; g < 2; g++) begin
         for (int b = 0; b < dwc_pkg::DATA_BEATS; b++) begin
            for (int j = 0; j < dwc_pkg::BYTE_W; j++) begin
               s_nxt.data[(g*dwc_pkg::BYTE_W+j)*dwc_pkg::BYTE_W+b] =
                  s_r.bt[b][g*dwc_pkg::TREE_LANES+j] ^
                  (s_r.dbi_en && !s_r.bt[b][g*dwc_pkg::TREE_LANES+dwc_pkg::BYTE_W]); // RQ16
            end
            s_nxt.mask[g*dwc_pkg::BYTE_W+b] =
               (s_r.dm_en && !s_r.bt[b][g*dwc_pkg::TREE_LANES+dwc_pkg::BYTE_W]) ||
               (s_r.bc4 && b >= dwc_pkg::HALF_BEATS);
         end
      end
      if (s_r.st == IDLE) begin
         s_nxt.data = s_r.data;
         s_nxt.mask = s_r.mask;
      end

      unique case (s_r.st)
         IDLE: begin
            if (wr_cmd) begin
               s_nxt.st = RECV;
               s_nxt.cnt = '0;
               s_nxt.early = 1'b0;
               // Order is fixed at zero for full bursts, only A2 counts
               s_nxt.a2 = s_r.bc4 && wr_col[2];                  // RQ9
            end
         end
         RECV: begin
            if (edge_det) begin
               s_nxt.bt[s_r.cnt] = s_r.ln_s2;
               s_nxt.cnt = s_r.cnt + 4'h1;
            end
            if (s_r.cnt == 4'(dwc_pkg::DATA_BEATS) && !s_r.early && !gated) begin
               s_nxt.early = 1'b1;
               s_nxt.commit = 1'b1;                              // RQ17
            end
            if (s_r.cnt == last && (s_r.early || gated)) begin
               s_nxt.st = s_r.crc_en ? CHECK : IDLE;             // RQ19
            end
         end
         CHECK: begin
            s_nxt.st = IDLE;
            s_nxt.calc = calc;
            s_nxt.recv = rx_crc;
            s_nxt.bad = bad;
            if (gated) begin
               s_nxt.commit = !bad;                              // RQ1
               s_nxt.cancel = bad;                               // RQ1
            end
            if (bad) begin
               s_nxt.err_cnt = s_r.err_cnt + 8'h01;
               s_nxt.alert_cnt = 8'(ALERT_CYC);                  // RQ15
            end
         end
      endcase

      // Alert pulls the pin low for a fixed number of cycles
      if (s_r.st != CHECK && s_r.alert_cnt != 8'h00) begin
         s_nxt.alert_cnt = s_r.alert_cnt - 8'h01;
      end
      s_nxt.alert_oe_n = (s_nxt.alert_cnt == 8'h00);
      s_nxt.alert_o = 1'b0;

      // Register port; hardware set wins over the clear
      if (reg_wr && reg_addr == dwc_pkg::A_CTRL) begin
         s_nxt.crc_en = reg_wdata[dwc_pkg::C_CRC_EN];
         s_nxt.dm_en  = reg_wdata[dwc_pkg::C_DM_EN];
         s_nxt.dbi_en = reg_wdata[dwc_pkg::C_DBI_EN];
         s_nxt.wid    = reg_wdata[dwc_pkg::C_WID_LO +: 2];
         s_nxt.bc4    = reg_wdata[dwc_pkg::C_BC4];
      end
      if (reg_wr && reg_addr == dwc_pkg::A_STATUS) begin
         s_nxt.err  = s_r.err && !reg_wdata[dwc_pkg::S_ERR];
         s_nxt.viol = s_r.viol && !reg_wdata[dwc_pkg::S_VIOL];
      end
      if (s_r.st == CHECK && bad) begin
         s_nxt.err = 1'b1;
      end
      // Flagged only; such commands are the controller's fault
      if (s_r.crc_en && (mpr_wr_cmd || pda_cmd)) begin
         s_nxt.viol = 1'b1;                                      // RQ2
      end
      if (reg_rd) begin
         unique case (reg_addr)
            dwc_pkg::A_CTRL:
               s_nxt.rdata = 32'({s_r.bc4, s_r.wid, s_r.dbi_en, s_r.dm_en, s_r.crc_en});
            dwc_pkg::A_STATUS:
               s_nxt.rdata = 32'({s_r.err_cnt, 5'h00, s_r.st != IDLE, s_r.viol, s_r.err});
            dwc_pkg::A_CRCS: s_nxt.rdata = {s_r.recv, s_r.calc};
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '0;
         s_r.alert_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata  = s_r.rdata;
   assign alert_o    = s_r.alert_o;
   assign alert_oe_n = s_r.alert_oe_n;
   assign arr_data   = s_r.data;
   assign arr_mask   = s_r.mask;
   assign arr_commit = s_r.commit;
   assign arr_cancel = s_r.cancel;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_alert_on_err: assert property (s_r.st == CHECK && bad |=> !alert_oe_n [*2]) // RQ15
      else $error("alert missing after mismatch");
   a_no_alert_ok: assert property (s_r.st == CHECK && !bad && alert_oe_n |=> alert_oe_n) // RQ15
      else $error("alert without mismatch");
   a_cancel_bad: assert property (arr_cancel |-> s_r.bad && s_r.dm_en && s_r.crc_en) // RQ1
      else $error("cancel without failing masked frame");
   a_gated_commit: assert property (arr_commit && s_r.crc_en && s_r.dm_en |->  // RQ1
      !s_r.bad && $past(s_r.st) == CHECK)
      else $error("masked write committed before check");
   a_one_result: assert property (arr_commit |-> !arr_cancel) // RQ19
      else $error("commit and cancel together");
   a_check_full: assert property (s_r.st == CHECK |-> $past(s_r.cnt) == 4'(dwc_pkg::BEATS)) // RQ19
      else $error("check before ten beats");
   a_err_count: assert property (s_r.st == CHECK && bad |=> s_r.err_cnt == $past(s_r.err_cnt) + 8'h01 && s_r.err) // RQ20
      else $error("error not recorded");
   a_early_commit: assert property (s_r.st == RECV && !s_r.early &&              // RQ17
      s_r.cnt == 4'(dwc_pkg::DATA_BEATS) && !(s_r.crc_en && s_r.dm_en) |=> arr_commit)
      else $error("unmasked write not committed");
   // A zero start keeps the checksum linear; any preset would break this
   a_crc_zero: assert property (s_r.st == CHECK |->                             // RQ6
      crc8(w_lo ^ w_hi) == (calc[7:0] ^ calc[15:8]))
      else $error("checksum not a function of the word");

   c_good_frame: cover property (s_r.st == CHECK && !bad);
   c_bad_masked: cover property (arr_cancel);
   c_wide_err: cover property (s_r.st == CHECK && bad && s_r.wid == dwc_pkg::W_X16);
   c_chop_a2: cover property (s_r.st == CHECK && s_r.bc4 && s_r.a2);
endmodule : dwc_checker

// ===== hdl/dwc_pkg.sv
/*
 * Constants for the write-checksum checker: frame layout, register map,
 * control and status field positions, checksum polynomial and alert timing.
 * Assumes a 250 MHz core clock and a controller that sends ten-beat frames.
 */
package dwc_pkg;
   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int unsigned CLK_MHZ   = 250;
   localparam int unsigned ALERT_NS  = 24;
   localparam int unsigned ALERT_CYC = (ALERT_NS * CLK_MHZ + 999) / 1000;

   // ==========================================================
   // Frame layout
   // ==========================================================
   localparam int unsigned WORD       = 72;
   localparam int unsigned BEATS      = 10;
   localparam int unsigned DATA_BEATS = 8;
   localparam int unsigned HALF_BEATS = 4;
   localparam int unsigned CRC_BEAT0  = 8;
   localparam int unsigned CRC_BEAT1  = 9;
   localparam int unsigned LANES      = 18;
   localparam int unsigned TREE_LANES = 9;
   localparam int unsigned X4_LANES   = 4;
   localparam int unsigned DQ_W       = 16;
   localparam int unsigned BYTE_W     = 8;
   localparam logic [7:0]  POLY       = 8'h07;

   // Device width encodings
   localparam logic [1:0] W_X4  = 2'h0;
   localparam logic [1:0] W_X8  = 2'h1;
   localparam logic [1:0] W_X16 = 2'h2;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [3:0] A_CTRL   = 4'h0;
   localparam logic [3:0] A_STATUS = 4'h1;
   localparam logic [3:0] A_CRCS   = 4'h2;
   localparam int unsigned C_CRC_EN = 0;
   localparam int unsigned C_DM_EN  = 1;
   localparam int unsigned C_DBI_EN = 2;
   localparam int unsigned C_WID_LO = 3;
   localparam int unsigned C_BC4    = 5;
   localparam int unsigned S_ERR    = 0;
   localparam int unsigned S_VIOL   = 1;
   localparam int unsigned S_BUSY   = 2;
   localparam int unsigned S_CNT_LO = 8;
endpackage : dwc_pkg

// ===== testbench/dwc_checker_tb.sv
/*
 * Bench of the write-checksum checker: registers, corrupted frames in every
 * width, good frames in the byte and wide widths and every mode, restricted commands.
 * Assumes the package, the design and the controller model.
 */
module dwc_checker_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic          clk, srst, reg_wr, reg_rd, wr_cmd, mpr_wr_cmd, pda_cmd, dqs_i;
   logic          alert_o, alert_oe_n, arr_commit, arr_cancel, m_start, m_bc4, m_a2;
   logic [1:0]    dm_n_i, m_wid;
   logic [2:0]    wr_col;
   logic [3:0]    reg_addr;
   logic [7:0]    cnt_e;
   logic [15:0]   dq_i, arr_mask, m_crc, smask;
   logic [31:0]   reg_wdata, reg_rdata, rv;
   logic [127:0]  arr_data, seen;
   logic [143:0]  m_d;
   logic [179:0]  m_fl;
   int            bad_count, check_count, cyc;
   dwc_checker    i_dwc_checker (.*);
   dwc_ctrl_model i_dwc_ctrl_model (.*);

   // ==========================================================
   // Clock, timeout, shared tasks
   // ==========================================================
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic chk(string n, logic [127:0] s, logic [127:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", n, e, s);
      end
   endtask : chk
   task automatic wr(logic [3:0] a, logic [31:0] v);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [3:0] a);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask : rd
   task automatic frame(logic [5:0] ct, logic a2, logic [143:0] d, logic [179:0] fl,
                        logic bad);
      int ncm, ncn, nal;
      {ncm, ncn, nal} = 0;
      wr(dwc_pkg::A_CTRL, {26'h0, ct});
      @(posedge clk);
      // Column bits A1:A0 set on purpose: full bursts must ignore them
      {wr_cmd, wr_col, m_wid, m_bc4, m_a2, m_d, m_fl} <= {1'b1, a2, 2'h3, ct[4:3], ct[5], a2, d, fl};
      @(posedge clk);
      {wr_cmd, m_start} <= 2'h1;
      repeat (90) begin
         @(posedge clk);
         m_start <= 1'b0;
         #1;
         ncm += (arr_commit === 1'b1);
         ncn += (arr_cancel === 1'b1);
         nal += (alert_oe_n === 1'b0);
         if (arr_commit === 1'b1) {seen, smask} = {arr_data, arr_mask};
      end
      chk("commit", ncm, (ct[1] && bad) ? 0 : 1);
      chk("cancel", ncn, ct[1] && bad);
      chk("alert", nal, bad ? dwc_pkg::ALERT_CYC : 0);
      cnt_e = cnt_e + 8'(bad);
      rd(dwc_pkg::A_STATUS);
      chk("err", rv[0], bad);
      chk("count", rv[15:8], cnt_e);
      // Checksum registers only follow frames that were checked
      if (ct[0]) begin
         rd(dwc_pkg::A_CRCS);
         chk("rx crc", ct[4] ? rv[31:16] : rv[23:16], ct[4] ? m_crc : m_crc[7:0]);
         if (!bad) chk("calc crc", ct[4] ? rv[15:0] : rv[7:0], ct[4] ? m_crc : m_crc[7:0]);
      end
      wr(dwc_pkg::A_STATUS, 32'h3);
   endtask : frame

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset();
      chk("alert idle", {alert_o, alert_oe_n}, 2'h1);
      wr(dwc_pkg::A_CRCS, 32'hffff_ffff);
      for (int a = 0; a < 16; a++) begin
         rd(4'(a));
         chk("reset read", rv, 32'h0);
      end
      $display("reset test done");
   endtask : t_reset
   task automatic t_frames();
      // Mask lanes all ones: nothing masked
      logic [143:0] dd = {8'hff, 64'hfedc_ba98_7654_3210, 8'hff, 64'h0123_4567_89ab_cdef};
      logic [5:0]   ct [8] = '{6'h0b, 6'h0b, 6'h0b, 6'h0b, 6'h0b, 6'h03, 6'h13, 6'h13};
      logic [179:0] fl [8] = '{180'h0, 180'h1 << 59, 180'h3 << 20, 180'h7 << 94,
                              180'hff << 36, 180'h1 << 55, 180'h1 << 30, 180'h0};
      for (int i = 0; i < 8; i++) begin
         frame(ct[i], 1'b0, dd, fl[i], i != 0 && i != 7);
         if (i == 0 || i == 7) begin
            // Byte device: upper lanes carry ones, only the lower half is data
            chk("array", i == 0 ? seen[63:0] : seen,
                i == 0 ? dd[63:0] : {dd[135:72], dd[63:0]});
            chk("mask", smask, 16'h0);
         end
      end
      $display("frame test done");
   endtask : t_frames
   task automatic t_modes();
      logic [143:0] dd = {72'h0, 8'hfd, 64'h0011_2233_4455_6677};
      frame(6'h09, 1'b0, dd | (144'h1 << 65), 180'h1 << 59, 1'b1);
      frame(6'h0d, 1'b0, dd, 180'h0, 1'b0);
      chk("dbi restore", seen[63:0], dd[63:0] ^ 64'h0202_0202_0202_0202);
      frame(6'h2b, 1'b1, dd | (144'hff << 64), 180'h0, 1'b0);
      chk("bc4 mask", smask[7:0], 8'hf0);
      // Checksum off: eight data beats, commit without any check
      frame(6'h08, 1'b0, dd | (144'hff << 64), 180'h0, 1'b0);
      chk("plain array", seen[63:0], dd[63:0]);
      $display("mode test done");
   endtask : t_modes
   task automatic t_viol();
      for (int i = 0; i < 3; i++) begin
         wr(dwc_pkg::A_CTRL, {31'h0, i != 0});
         @(posedge clk);
         {mpr_wr_cmd, pda_cmd} <= (i == 2) ? 2'h1 : 2'h2;
         @(posedge clk);
         {mpr_wr_cmd, pda_cmd} <= 2'h0;
         rd(dwc_pkg::A_STATUS);
         chk("viol", rv[1], i != 0);
         wr(dwc_pkg::A_STATUS, 32'h2);
         rd(dwc_pkg::A_STATUS);
         chk("viol clear", rv[1], 1'b0);
      end
      $display("command test done");
   endtask : t_viol
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   initial begin
      {srst, reg_wr, reg_rd, wr_cmd, mpr_wr_cmd, pda_cmd, m_start} = 7'h40;
      {reg_addr, reg_wdata, wr_col, m_wid, m_bc4, m_a2, m_d, m_fl, cnt_e} = '0;
      {bad_count, check_count, cyc} = 0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_frames();
      t_modes();
      t_viol();
      test_done();
   end
endmodule : dwc_checker_tb

// ===== testbench/dwc_ctrl_model.sv
/*
 * Controller model: builds one checksummed ten-beat write frame and
 * drives it on the strobe, data and mask pins.
 * Assumes the bench sets the frame fields before raising m_start.
 */
module dwc_ctrl_model (
   // Frame request
   input  wire logic         m_start,
   input  wire logic [1:0]   m_wid,
   input  wire logic         m_bc4,
   input  wire logic         m_a2,
   input  wire logic [143:0] m_d,
   input  wire logic [179:0] m_fl,
   // Pins toward the device, and the frame checksum back to the bench
   output logic              dqs_i,
   output logic [15:0]       dq_i,
   output logic [1:0]        dm_n_i,
   output logic [15:0]       m_crc
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [143:0] w;
   logic [179:0] f;

   // ==========================================================
   // Checksum, serial from the top bit, cleared per word
   // ==========================================================
   function automatic logic [7:0] crc8(logic [71:0] x);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 71; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ x[i]) ? dwc_pkg::POLY : 8'h00);
      end
      return c;
   endfunction : crc8

   initial begin
      {dqs_i, dq_i, dm_n_i, m_crc} = {1'b0, 16'hffff, 2'h3, 16'h0000};
   end

   // ==========================================================
   // Frame build and drive
   // ==========================================================
   always @(posedge m_start) begin
      for (int i = 0; i < 144; i++) begin
         w[i] = (m_bc4 && i[2] != m_a2) ? 1'b1 : m_d[i];
      end
      if (m_wid == dwc_pkg::W_X4) w[143:32] = '1;
      if (m_wid == dwc_pkg::W_X8) w[143:72] = '1;
      m_crc = {crc8(w[143:72]), crc8(w[71:0])};
      f = '1;
      for (int k = 0; k < 8; k++) begin
         for (int n = 0; n < 18; n++) begin
            f[18*k+n] = m_bc4 ? (k < 4 ? w[8*n+k+4*m_a2] : 1'b1) : w[8*n+k];
         end
      end
      for (int n = 0; n < 8; n++) begin
         f[144+n] = (m_wid == dwc_pkg::W_X4 && n > 3) ? 1'b1 : m_crc[n];
         f[153+n] = m_crc[8+n];
         if (m_wid == dwc_pkg::W_X4 && n < 4) f[162+n] = m_crc[4+n];
      end
      f = f ^ m_fl;
      // Offset keeps strobe edges off the core clock edges
      #3;
      for (int k = 0; k < 10; k++) begin
         {dm_n_i[1], dq_i[15:8], dm_n_i[0], dq_i[7:0]} = f[18*k +: 18];
         #8 dqs_i = ~dqs_i;
         #8;
      end
      // Released pins: no pull, so show the inverse rather than a stale value
      {dm_n_i[1], dq_i[15:8], dm_n_i[0], dq_i[7:0]} = ~f[162 +: 18];
   end
endmodule : dwc_ctrl_model
